// ### hw/pml_ctrl_map.vh
// Constants for the protection-mode and password-unlock host controller.
// Assumes an Avalon-MM master on clk_sys and a x16 flash bus on the pins.
`ifndef PML_CTRL_MAP_VH
`define PML_CTRL_MAP_VH
// Register word offsets (byte address = 4 * index).
`define PML_REG_CTRL 4'h0
`define PML_REG_STAT 4'h1
`define PML_REG_LOCKWD 4'h2
`define PML_REG_PW0 4'h3
`define PML_REG_PW1 4'h4
`define PML_REG_PW2 4'h5
`define PML_REG_PW3 4'h6
`define PML_REG_RDATA 4'h7
`define PML_REG_SECT 4'h8
// Command codes written to the control register bits 3:0.
`define PML_CMD_RDLOCK 4'h1
`define PML_CMD_PGMLOCK 4'h2
`define PML_CMD_UNLOCK 4'h3
`define PML_CMD_GLCLR 4'h4
`define PML_CMD_PWPGM 4'h5
`define PML_CMD_PWRD 4'h6
// Lock register fields.
`define PML_LK_FACTORY 0
`define PML_LK_PERSIST 1
`define PML_LK_PASSWD 2
`define PML_LK_CUSTOMER 6
`define PML_LK_RSVD_MASK 16'hffb8
`define PML_LK_DEFAULT 16'hfe7e
// Status word bits from the device.
`define PML_ST_READY 7
`define PML_ST_PGMFAIL 4
`define PML_ST_PROT 1
`define PML_ST_BUFABT 3
// Flash status command and timing.
`define PML_FL_STATCMD 16'h0070
`define PML_CLK_MHZ 250
`define PML_UNLOCK_GAP_US 120
`define PML_PULSE_CYC 4'h8
`define PML_PULSE_W 4
`endif

// ### hw/pml_gap_timer.v
// Spacing timer that holds off a new unlock attempt for a fixed count.
// Assumes a single clock and a one-cycle start pulse.
`timescale 1ns/1ns
`default_nettype none
module pml_gap_timer #(
    parameter CYCLES = 30000
) (
    input wire clk_sys,
    input wire rst,
    input wire start,
    output reg busy
);
    reg [15:0] countReg;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            countReg <= 16'h0000;
            busy <= 1'b0;
        end else if (start) begin
            countReg <= CYCLES[15:0];
            busy <= 1'b1;
        end else if (countReg != 16'h0000) begin
            countReg <= countReg - 16'h0001;
            busy <= (countReg != 16'h0001);
        end else begin
            busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### hw/pml_host_ctrl.v
// Host controller for lock register, global guard latch and password unlock.
// Assumes an Avalon-MM master on clk_sys; flash pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none
`include "pml_ctrl_map.vh"
// What this block does
// - Host drives reserved lock bits as one when programming.
// - Unlock words sent in order 0 to 3; match needs all four words.
// - Unlock attempts spaced at least 120 us; host polls status first.
// - Host refuses the password bit until the password has been read back.
module pml_host_ctrl #(
    parameter GAP_CYCLES = `PML_UNLOCK_GAP_US * `PML_CLK_MHZ
) (
    input wire clk_sys,
    input wire rst,
    input wire [5:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWriteData,
    output reg [31:0] avsReadData,
    output reg avsWaitRequest,
    output reg [3:0] flAddr,
    input wire [15:0] flDqIn,
    output reg [15:0] flDqOut,
    output reg flDqOe,
    output reg flCeN,
    output reg flWeN,
    output reg flOeN,
    input wire flReadyBusy
);
    localparam S_IDLE = 7'h01;
    localparam S_WR = 7'h02;
    localparam S_RD = 7'h04;
    localparam S_NEXT = 7'h08;
    localparam S_POLL = 7'h10;
    localparam S_DONE = 7'h20;
    localparam S_REFUSE = 7'h40;

    reg [6:0] stateReg;
    reg [3:0] cmdReg;
    reg [15:0] lockWordReg;
    reg [15:0] pwReg [0:3];
    reg [15:0] sectReg;
    reg [15:0] rdDataReg;
    reg [15:0] statReg;
    reg [15:0] lockSeenReg;
    reg doneReg;
    reg refusedReg;
    // Set once the password has been read back; the mode bit, once read back, hides it until the next reset.
    reg pwCheckedReg;
    reg [2:0] stepReg;
    reg [3:0] pulseReg;
    reg [15:0] dqSyncA;
    reg [15:0] dqSyncB;
    reg rbSyncA;
    reg rbSyncB;
    reg gapStart;
    wire gapBusy;

    pml_gap_timer #(.CYCLES(GAP_CYCLES)) pml_gap_timer_i (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(gapStart),
        .busy(gapBusy)
    );

    // Index decode shared by read and write paths.
    function [3:0] regIndex;
        input [5:0] addr;
        begin
            regIndex = addr[5:2];
        end
    endfunction

    // Mode bit is programmed when read back as zero.
    function pwModeSet;
        input [15:0] lk;
        begin
            pwModeSet = ~lk[`PML_LK_PASSWD];
        end
    endfunction

    // Number of bus writes per command.
    function [2:0] stepCount;
        input [3:0] cmd;
        begin
            case (cmd)
                `PML_CMD_UNLOCK: stepCount = 3'h4;
                `PML_CMD_PWPGM: stepCount = 3'h4;
                default: stepCount = 3'h1;
            endcase
        end
    endfunction

    wire [3:0] wIdx = regIndex(avsAddress);
    wire busyNow = (stateReg != S_IDLE);
    // Lock word with reserved positions forced to one.
    wire [15:0] lockMasked = lockWordReg | `PML_LK_RSVD_MASK;
    wire bothModes = ~lockWordReg[`PML_LK_PERSIST] & ~lockWordReg[`PML_LK_PASSWD];
    wire pwBitAsked = ~lockWordReg[`PML_LK_PASSWD];
    wire pwLocked = pwModeSet(lockSeenReg);

    integer i;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dqSyncA <= 16'h0000;
            dqSyncB <= 16'h0000;
            rbSyncA <= 1'b0;
            rbSyncB <= 1'b0;
        end else begin
            dqSyncA <= flDqIn;
            dqSyncB <= dqSyncA;
            rbSyncA <= flReadyBusy;
            rbSyncB <= rbSyncA;
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avsWaitRequest <= 1'b1;
            avsReadData <= 32'h00000000;
            cmdReg <= 4'h0;
            lockWordReg <= 16'hffff;
            for (i = 0; i < 4; i = i + 1) begin
                pwReg[i] <= 16'hffff;
            end
            sectReg <= 16'h0000;
        end else begin
            avsWaitRequest <= 1'b1;
            if ((avsRead || avsWrite) && avsWaitRequest) begin
                avsWaitRequest <= 1'b0;
            end
            // A write lands only at the edge where the master sees waitrequest low.
            if (avsWrite && !avsWaitRequest) begin
                case (wIdx)
                    `PML_REG_CTRL: cmdReg <= busyNow ? cmdReg : avsWriteData[3:0];
                    `PML_REG_LOCKWD: lockWordReg <= avsWriteData[15:0];
                    `PML_REG_PW0: pwReg[0] <= avsWriteData[15:0];
                    `PML_REG_PW1: pwReg[1] <= avsWriteData[15:0];
                    `PML_REG_PW2: pwReg[2] <= avsWriteData[15:0];
                    `PML_REG_PW3: pwReg[3] <= avsWriteData[15:0];
                    `PML_REG_SECT: sectReg <= avsWriteData[15:0];
                    default: ;
                endcase
            end
            if (avsRead && avsWaitRequest) begin
                case (wIdx)
                    `PML_REG_CTRL: avsReadData <= {28'h0000000, cmdReg};
                    `PML_REG_STAT: avsReadData <= {13'h0000, gapBusy, refusedReg,
                        doneReg, statReg};
                    `PML_REG_LOCKWD: avsReadData <= {16'h0000, lockSeenReg};
                    `PML_REG_RDATA: avsReadData <= {16'h0000, rdDataReg};
                    `PML_REG_SECT: avsReadData <= {16'h0000, sectReg};
                    default: avsReadData <= 32'h00000000;
                endcase
            end
            if (stateReg == S_DONE || stateReg == S_REFUSE) begin
                cmdReg <= 4'h0;
            end
        end
    end

    // Flash sequencer: one write or read per step, with status polling after the last write step.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stateReg <= S_IDLE;
            flAddr <= 4'h0;
            flDqOut <= 16'h0000;
            flDqOe <= 1'b0;
            flCeN <= 1'b1;
            flWeN <= 1'b1;
            flOeN <= 1'b1;
            stepReg <= 3'h0;
            pulseReg <= 4'h0;
            statReg <= 16'h0000;
            rdDataReg <= 16'h0000;
            lockSeenReg <= `PML_LK_DEFAULT;
            doneReg <= 1'b0;
            refusedReg <= 1'b0;
            pwCheckedReg <= 1'b0;
            gapStart <= 1'b0;
        end else begin
            gapStart <= 1'b0;
            case (stateReg)
                S_IDLE: begin
                    stepReg <= 3'h0;
                    if (cmdReg != 4'h0) begin
                        doneReg <= 1'b0;
                        refusedReg <= 1'b0;
                        if ((cmdReg == `PML_CMD_PGMLOCK && bothModes) ||
                            (cmdReg == `PML_CMD_PGMLOCK && pwBitAsked && !pwCheckedReg) ||
                            (cmdReg == `PML_CMD_UNLOCK && gapBusy) ||
                            ((cmdReg == `PML_CMD_PWPGM || cmdReg == `PML_CMD_PWRD)
                            && pwLocked)) begin
                            stateReg <= S_REFUSE;
                        end else if (cmdReg == `PML_CMD_RDLOCK || cmdReg == `PML_CMD_PWRD) begin
                            stateReg <= S_RD;
                            flAddr <= cmdReg == `PML_CMD_PWRD ? 4'h0 : 4'h1;
                        end else begin
                            stateReg <= S_WR;
                        end
                        pulseReg <= `PML_PULSE_CYC;
                    end
                end
                S_WR: begin
                    flCeN <= 1'b0;
                    flWeN <= 1'b0;
                    flDqOe <= 1'b1;
                    flAddr <= {1'b0, stepReg};
                    case (cmdReg)
                        `PML_CMD_PGMLOCK: flDqOut <= lockMasked;
                        `PML_CMD_GLCLR: flDqOut <= 16'h0000;
                        `PML_CMD_UNLOCK: flDqOut <= pwReg[stepReg[1:0]] ^ sectReg;
                        default: flDqOut <= pwReg[stepReg[1:0]];
                    endcase
                    pulseReg <= pulseReg - 4'h1;
                    if (pulseReg == 4'h1) begin
                        stateReg <= S_NEXT;
                        flWeN <= 1'b1;
                    end
                end
                S_NEXT: begin
                    flCeN <= 1'b1;
                    flDqOe <= 1'b0;
                    pulseReg <= `PML_PULSE_CYC;
                    if (stepReg + 3'h1 < stepCount(cmdReg)) begin
                        stepReg <= stepReg + 3'h1;
                        stateReg <= S_WR;
                    end else begin
                        if (cmdReg == `PML_CMD_UNLOCK) begin
                            gapStart <= 1'b1;
                        end
                        stateReg <= S_POLL;
                    end
                end
                S_POLL: begin
                    // Status word read after each write command; ready bit with the ready/busy pin high ends the wait.
                    flCeN <= 1'b0;
                    flOeN <= 1'b0;
                    pulseReg <= pulseReg - 4'h1;
                    if (pulseReg == 4'h1) begin
                        flOeN <= 1'b1;
                        flCeN <= 1'b1;
                        statReg <= dqSyncB;
                        pulseReg <= `PML_PULSE_CYC;
                        // Busy output and ready bit both gate completion.
                        if (dqSyncB[`PML_ST_READY] && rbSyncB) begin
                            stateReg <= (cmdReg == `PML_CMD_PGMLOCK) ? S_RD : S_DONE;
                        end
                    end
                end
                S_RD: begin
                    flCeN <= 1'b0;
                    flOeN <= 1'b0;
                    pulseReg <= pulseReg - 4'h1;
                    if (pulseReg == 4'h1) begin
                        flOeN <= 1'b1;
                        flCeN <= 1'b1;
                        if (cmdReg == `PML_CMD_PWRD) begin
                            rdDataReg <= dqSyncB;
                            pwCheckedReg <= 1'b1;
                        end else begin
                            lockSeenReg <= dqSyncB;
                        end
                        stateReg <= S_DONE;
                    end
                end
                S_DONE: begin
                    // Fail flags from status show a failed unlock or protected area.
                    doneReg <= 1'b1;
                    stateReg <= S_IDLE;
                end
                S_REFUSE: begin
                    refusedReg <= 1'b1;
                    doneReg <= 1'b1;
                    stateReg <= S_IDLE;
                end
                default: stateReg <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### test/pml_host_ctrl_properties.sv
// Checker for the host controller's bus handshake and flash pin strobes.
// Assumes binding onto pml_host_ctrl, one clock, reset active high.
`timescale 1ns/1ns
`default_nettype none
module pml_host_ctrl_props #(
    parameter GAP_CYCLES = 30000
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsReadData,
    input wire logic avsWaitRequest,
    input wire logic flDqOe,
    input wire logic flCeN,
    input wire logic flWeN,
    input wire logic flOeN
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence weLowPulse;
        !flWeN [*7] ##1 flWeN;
    endsequence
    waitAnswer_a: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
        else $error("access not answered in one cycle");
    waitOne_a: assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("waitrequest low too long");
    waitCause_a: assert property (!avsWaitRequest |-> $past(avsRead || avsWrite))
        else $error("answer without request");
    rdataHold_a: assert property ($changed(avsReadData) |-> !avsWaitRequest && avsRead)
        else $error("read data moved outside a read answer");
    strobeLen_a: assert property ($fell(flWeN) |-> weLowPulse)
        else $error("write strobe not seven cycles");
    driveOnWrite_a: assert property (!flWeN |-> flDqOe && !flCeN)
        else $error("write strobe without driven data");
    noContend_a: assert property (flDqOe |-> flOeN)
        else $error("host drives while output enabled");
    readSelect_a: assert property (!flOeN |-> !flCeN && flWeN)
        else $error("status read without chip select");
endmodule
bind pml_host_ctrl pml_host_ctrl_props #(.GAP_CYCLES(GAP_CYCLES)) pml_host_ctrl_props_i (
    .clk_sys(clk_sys), .rst(rst), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .flDqOe(flDqOe),
    .flCeN(flCeN), .flWeN(flWeN), .flOeN(flOeN));
`default_nettype wire

// ### test/pml_flash_model.sv
// Behavioural flash device: lock register, status word and ready output.
// Assumes a status read follows every host write; a ready status read returns to array reads.
`timescale 1ns/1ns
`default_nettype none
module pml_flash_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] flDqOut,
    input wire logic flCeN,
    input wire logic flWeN,
    input wire logic flOeN,
    output logic [15:0] flDqIn,
    output logic flReadyBusy
);
    logic [15:0] lockReg = 16'hfe7e;
    logic [15:0] lastQ = 16'h0000;
    logic statMode = 1'b0;
    logic rdySeen = 1'b0;
    logic tgl = 1'b0;
    logic fail = 1'b0;
    logic weLast = 1'b1;
    logic oeLast = 1'b1;
    logic failNow;
    int busy = 0;
    assign flReadyBusy = (busy == 0);
    assign failNow = (flDqOut[2:1] == 2'b00) ||
        (flDqOut[2:1] != 2'b11 && lockReg[2:1] != 2'b11);
    // Strobes are seen one clock late. The busy count only runs while no read is open,
    // so that one status read never mixes busy and ready.
    always @(posedge clk_sys) begin
        weLast <= flWeN;
        oeLast <= flOeN;
        if (!flCeN && !flOeN) lastQ <= flDqIn;
        if (rst) begin
            busy <= 0;
        end else if (flWeN && !weLast && !flCeN) begin
            statMode <= 1'b1;
            // Only words with bits 15:9 all one count as lock data.
            if (flDqOut[15:9] == 7'h7f) begin
                fail <= failNow;
                if (!failNow) lockReg <= lockReg & (flDqOut | 16'hffb8);
                busy <= 5;
            end
        end else if (busy > 0 && flOeN) begin
            busy <= busy - 1;
        end
        if (!flOeN && oeLast) begin
            rdySeen <= (busy == 0);
            if (busy != 0) tgl <= ~tgl;
        end
        if (flOeN && !oeLast && rdySeen) statMode <= 1'b0;
    end
    // A released bus shows the inverse of the last word, never a stale copy.
    always @* begin
        if (!flCeN && !flOeN)
            flDqIn = statMode ? {8'h00, busy == 0, tgl, 1'b0, fail, 2'b00, fail, 1'b0}
                : lockReg;
        else flDqIn = ~lastQ;
    end
endmodule
`default_nettype wire

// ### test/pml_host_ctrl_bench.sv
// Self-checking bench for the host controller against the flash model.
// Assumes a 250 MHz clock and a shortened unlock gap of 50 cycles.
`timescale 1ns/1ns
`default_nettype none
module pml_host_ctrl_bench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [5:0] avsAddress = 6'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    logic [31:0] rdat;
    wire [31:0] avsReadData;
    wire avsWaitRequest, flDqOe, flCeN, flWeN, flOeN, flReadyBusy;
    wire [15:0] flDqOut, flDqIn;
    int n_mismatch = 0;
    int checks_done = 0;
    always #2 clk_sys = ~clk_sys;
    pml_host_ctrl #(.GAP_CYCLES(50)) pml_host_ctrl_i (.clk_sys(clk_sys), .rst(rst),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .flAddr(), .flDqIn(flDqIn), .flDqOut(flDqOut),
        .flDqOe(flDqOe), .flCeN(flCeN), .flWeN(flWeN), .flOeN(flOeN),
        .flReadyBusy(flReadyBusy));
    pml_flash_model pml_flash_model_i (.clk_sys(clk_sys), .rst(rst), .flDqOut(flDqOut),
        .flCeN(flCeN), .flWeN(flWeN), .flOeN(flOeN), .flDqIn(flDqIn),
        .flReadyBusy(flReadyBusy));
    task automatic tally_and_finish();
        if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avsAddress <= {idx, 2'b00};
        avsWrite <= wr;
        avsRead <= ~wr;
        avsWriteData <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 64);
        rdat = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        if (avsWaitRequest !== 1'b0) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    // Polls the command field until the sequencer clears it; a hang ends the run.
    task automatic runCmd(input logic [3:0] c);
        int n;
        n = 0;
        bus(1'b1, 4'h0, {28'h0, c});
        do begin
            bus(1'b0, 4'h0, 32'h0);
            n++;
        end while (rdat[3:0] !== 4'h0 && n < 500);
        if (rdat[3:0] !== 4'h0) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    task automatic s_reset();
        bus(1'b0, 4'h2, 32'h0);
        chk(rdat, 32'h0000fe7e);
        bus(1'b1, 4'h9, 32'h5);
        bus(1'b0, 4'h9, 32'h0);
        chk(rdat, 32'h0);
    endtask
    task automatic s_region();
        bus(1'b1, 4'h2, 32'hffbf);
        runCmd(4'h2);
        runCmd(4'h1);
        bus(1'b0, 4'h2, 32'h0);
        chk(rdat, 32'h0000fe3e);
    endtask
    task automatic s_both();
        bus(1'b1, 4'h2, 32'hfff9);
        runCmd(4'h2);
        bus(1'b0, 4'h1, 32'h0);
        chk({31'h0, rdat[17]}, 32'h1);
        runCmd(4'h1);
        bus(1'b0, 4'h2, 32'h0);
        chk(rdat, 32'h0000fe3e);
    endtask
    task automatic s_gap();
        for (int i = 3; i < 7; i++) bus(1'b1, i[3:0], 32'h1234 + i);
        runCmd(4'h3);
        bus(1'b0, 4'h1, 32'h0);
        chk({30'h0, rdat[18:17]}, 32'h2);
        runCmd(4'h3);
        bus(1'b0, 4'h1, 32'h0);
        chk({31'h0, rdat[17]}, 32'h1);
    endtask
    task automatic s_pwmode();
        bus(1'b1, 4'h2, 32'hfffb);
        runCmd(4'h2);
        bus(1'b0, 4'h1, 32'h0);
        chk({31'h0, rdat[17]}, 32'h1);
        runCmd(4'h5);
        runCmd(4'h6);
        runCmd(4'h2);
        bus(1'b0, 4'h1, 32'h0);
        chk({31'h0, rdat[17]}, 32'h0);
        runCmd(4'h1);
        bus(1'b0, 4'h2, 32'h0);
        chk(rdat, 32'h0000fe3a);
        runCmd(4'h5);
        bus(1'b0, 4'h1, 32'h0);
        chk({31'h0, rdat[17]}, 32'h1);
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        s_reset();
        s_region();
        s_both();
        s_gap();
        s_pwmode();
        tally_and_finish();
    end
endmodule
`default_nettype wire
